// *** hdl/ckr_pkg.sv ***
// Constants, register layout and state codes for the clock source and reset controller.
// Assumes a single core clock; oscillators and voltage detectors are outside this block.
package ckr_pkg;
  // Register map
  localparam logic [7:0] CKR_CFG_ADDR = 8'hF8;
  localparam logic [7:0] CKR_CFG_RESET = 8'h00;
  localparam logic [7:0] CKR_READ_IDLE = 8'h00;
  // Field positions in the configuration register
  localparam int CKR_BIT_RESUME_LONG = 7;
  localparam int CKR_WAKE_HI = 6;
  localparam int CKR_WAKE_LO = 4;
  localparam int CKR_BIT_DROOP_DIS = 3;
  localparam int CKR_BIT_TUNE_EN = 2;
  localparam int CKR_BIT_CLKOUT_DIS = 1;
  localparam int CKR_BIT_EXT_EN = 0;
  // Restart values
  localparam logic [15:0] CKR_RESET_VECTOR = 16'h0000;
  localparam logic [7:0] CKR_STACK_RESET = 8'h00;
  // Timing, figures in microseconds at the core clock rate
  localparam int CKR_CLK_MHZ = 125;
  localparam int CKR_RESUME_LONG_US = 4000;
  localparam int CKR_RESUME_SHORT_US = 128;
  localparam int CKR_INT_WAKE_US = 8;
  localparam int CKR_INT_START_US = 1;
  localparam int CKR_STARTUP_US = 1000;
  localparam int CKR_CNT_W = 20;
  localparam int CKR_RESUME_LONG_CYC = CKR_RESUME_LONG_US * CKR_CLK_MHZ;
  localparam int CKR_RESUME_SHORT_CYC = CKR_RESUME_SHORT_US * CKR_CLK_MHZ;
  localparam int CKR_STARTUP_CYC = CKR_STARTUP_US * CKR_CLK_MHZ;
  localparam logic [CKR_CNT_W-1:0] CKR_INT_WAKE_CYC =
    CKR_CNT_W'(CKR_INT_WAKE_US * CKR_CLK_MHZ);
  localparam logic [CKR_CNT_W-1:0] CKR_INT_START_CYC =
    CKR_CNT_W'(CKR_INT_START_US * CKR_CLK_MHZ);
  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    CKR_ST_HOLD     = 7'b000_0001,
    CKR_ST_STARTUP  = 7'b000_0010,
    CKR_ST_RUN      = 7'b000_0100,
    CKR_ST_OSC_WAIT = 7'b000_1000,
    CKR_ST_RESUME   = 7'b001_0000,
    CKR_ST_SUSPEND  = 7'b010_0000,
    CKR_ST_WDOG     = 7'b100_0000
  } ckr_state_t;
endpackage : ckr_pkg

// *** hdl/ckr_delay_timer.sv ***
// Down-counting delay timer used for start-up, oscillator start and resume delays.
// Assumes load is a one-cycle strobe; done pulses one cycle when the count runs out.
`timescale 1ns/1ps
module ckr_delay_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // Status
  output logic o_busy,
  output logic o_done
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;
  wire logic last = busy_reg && (cnt_reg <= W'(1));

  // Next-state selection
  assign cnt_next = i_load ? i_count : (busy_reg ? cnt_reg - W'(1) : cnt_reg);
  assign busy_next = i_load ? 1'b1 : (busy_reg && !last);
  assign done_next = !i_load && last;

  // Counter registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;
endmodule : ckr_delay_timer

// *** hdl/ckr_clock_reset_ctrl.sv ***
// Clock source selection, clock configuration register and reset sequencing.
// Assumes oscillators, voltage detectors, watchdog and wake-up timer sit outside,
// and that the processor I/O bus is synchronous to I_CORE_CLK.
`timescale 1ns/1ps
module ckr_clock_reset_ctrl
  import ckr_pkg::*;
#(
  parameter int RESUME_LONG_CYC = ckr_pkg::CKR_RESUME_LONG_CYC,
  parameter int RESUME_SHORT_CYC = ckr_pkg::CKR_RESUME_SHORT_CYC,
  parameter int STARTUP_CYC = ckr_pkg::CKR_STARTUP_CYC
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  // Processor I/O bus
  input wire logic [7:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  output logic [7:0] O_IO_RDATA,
  // Voltage and watchdog reset sources
  input wire logic I_SUPPLY_DROOP,
  input wire logic I_DEEP_UNDERVOLTAGE,
  input wire logic I_WATCHDOG_EXPIRY,
  // Suspend and wake
  input wire logic I_SUSPEND_REQ,
  input wire logic I_WAKE_EVENT,
  input wire logic I_WAKE_TICK,
  input wire logic I_WAKE_INT_EN,
  input wire logic I_USB_TRAFFIC,
  // Oscillator handshakes
  input wire logic I_INT_OSC_CLK,
  input wire logic I_EXT_OSC_STABLE,
  output logic O_INT_OSC_EN,
  output logic O_EXT_OSC_EN,
  output logic O_CLK_SRC_EXT,
  output logic O_SYS_CLK_EN,
  output logic O_CLK_TUNE_EN,
  // Resonator pins and auxiliary port
  input wire logic I_RESONATOR_INPUT_PIN,
  output logic O_RESONATOR_IN_PULLDOWN,
  output logic O_RESONATOR_OUTPUT_PIN,
  output logic O_RESONATOR_OUTPUT_OE_N,
  output logic O_AUX_PORT_BIT_ONE,
  // Wake-up timer control
  output logic [2:0] O_WAKE_PERIOD,
  output logic O_WAKE_IRQ,
  // Reset outputs to the core
  output logic O_CHIP_RESET,
  output logic O_CPU_HOLD,
  output logic O_PARTIAL_SUSPEND,
  output logic O_DROOP_DETECT_EN,
  output logic O_CPU_RESTART,
  output logic [15:0] O_RESET_VECTOR,
  output logic [7:0] O_STACK_RESET_VALUE,
  // Reset cause flags
  input wire logic I_CLR_DROOP_FLAG,
  input wire logic I_CLR_WDOG_FLAG,
  output logic O_DROOP_RESET_FLAG,
  output logic O_WDOG_RESET_FLAG
);
  import ckr_pkg::*;

  // Resized delay figures
  localparam logic [CKR_CNT_W-1:0] LONG_C = CKR_CNT_W'(RESUME_LONG_CYC);
  localparam logic [CKR_CNT_W-1:0] SHORT_C = CKR_CNT_W'(RESUME_SHORT_CYC);
  localparam logic [CKR_CNT_W-1:0] START_C = CKR_CNT_W'(STARTUP_CYC);

  ckr_state_t state_reg;
  ckr_state_t state_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic clk_ext_reg;
  logic clk_ext_next;
  logic droop_flag_reg;
  logic wdog_flag_reg;
  logic [7:0] rdata_reg;
  logic xout_reg;
  logic aux_reg;
  logic wake_irq_reg;
  logic restart_reg;
  logic tmr_load;
  logic [CKR_CNT_W-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;

  // Bus decode
  wire logic cfg_hit = (I_IO_ADDR == CKR_CFG_ADDR);
  wire logic cfg_wr = I_IO_WR && cfg_hit && (state_reg == CKR_ST_RUN);
  wire logic cfg_rd = I_IO_RD && cfg_hit;

  // Reset source decode
  wire logic in_suspend = (state_reg == CKR_ST_SUSPEND);
  wire logic droop_armed = !cfg_reg[CKR_BIT_DROOP_DIS] && !in_suspend;
  wire logic volt_reset = I_DEEP_UNDERVOLTAGE || (I_SUPPLY_DROOP && droop_armed);
  wire logic supply_ok = !I_DEEP_UNDERVOLTAGE && !I_SUPPLY_DROOP;
  wire logic wdog_reset = I_WATCHDOG_EXPIRY && !volt_reset;

  // Switch request: bit 0 rising in internal mode
  wire logic ext_rise = cfg_wr && I_IO_WDATA[CKR_BIT_EXT_EN] && !clk_ext_reg;
  wire logic run_state = (state_reg == CKR_ST_RUN);
  wire logic osc_wait = (state_reg == CKR_ST_OSC_WAIT);
  wire logic ext_stable = clk_ext_reg && I_EXT_OSC_STABLE;
  wire logic int_started = !clk_ext_reg && tmr_done;

  // Resume delay picked by clock mode
  wire logic [CKR_CNT_W-1:0] ext_delay =
    cfg_reg[CKR_BIT_RESUME_LONG] ? LONG_C : SHORT_C;
  wire logic [CKR_CNT_W-1:0] resume_delay =
    clk_ext_reg ? ext_delay : CKR_INT_WAKE_CYC;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CKR_ST_HOLD: begin
        if (supply_ok) begin
          state_next = CKR_ST_STARTUP;
        end
      end
      CKR_ST_STARTUP: begin
        if (tmr_done) begin
          state_next = CKR_ST_RUN;
        end
      end
      CKR_ST_RUN: begin
        if (ext_rise) begin
          state_next = CKR_ST_OSC_WAIT;
        end else if (I_SUSPEND_REQ) begin
          state_next = CKR_ST_SUSPEND;
        end
      end
      CKR_ST_OSC_WAIT: begin
        if (ext_stable || int_started) begin
          state_next = CKR_ST_RESUME;
        end
      end
      CKR_ST_RESUME: begin
        if (tmr_done) begin
          state_next = CKR_ST_RUN;
        end
      end
      CKR_ST_SUSPEND: begin
        if (I_WAKE_EVENT) begin
          state_next = CKR_ST_OSC_WAIT;
        end
      end
      CKR_ST_WDOG: begin
        if (!I_WATCHDOG_EXPIRY) begin
          state_next = CKR_ST_RUN;
        end
      end
      default: begin
        state_next = CKR_ST_HOLD;
      end
    endcase
    if (volt_reset) begin
      state_next = CKR_ST_HOLD;
    end else if (wdog_reset) begin
      state_next = CKR_ST_WDOG;
    end
  end

  // Timer loads on entry to each timed state
  assign tmr_load = (state_reg == CKR_ST_HOLD && state_next == CKR_ST_STARTUP)
    || (state_next == CKR_ST_OSC_WAIT && state_reg != CKR_ST_OSC_WAIT)
    || (osc_wait && state_next == CKR_ST_RESUME);
  assign tmr_count = (state_reg == CKR_ST_HOLD) ? START_C :
    (osc_wait ? resume_delay : CKR_INT_START_CYC);

  // Clock mode: forced internal by voltage reset, kept by watchdog
  always_comb begin
    clk_ext_next = clk_ext_reg;
    if (volt_reset) begin
      clk_ext_next = 1'b0;
    end else if (ext_rise) begin
      clk_ext_next = 1'b1;
    end else if (in_suspend && I_WAKE_EVENT) begin
      clk_ext_next = cfg_reg[CKR_BIT_EXT_EN];
    end
  end

  // Configuration register: resets clear all bits, writes store all bits
  always_comb begin
    cfg_next = cfg_reg;
    if (volt_reset || wdog_reset) begin
      cfg_next = CKR_CFG_RESET;
    end else if (cfg_wr) begin
      cfg_next = I_IO_WDATA;
    end
  end

  // Sequencer, clock mode and configuration registers
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= CKR_ST_HOLD;
      clk_ext_reg <= 1'b0;
      cfg_reg <= CKR_CFG_RESET;
    end else begin
      state_reg <= state_next;
      clk_ext_reg <= clk_ext_next;
      cfg_reg <= cfg_next;
    end
  end

  // Reset cause flags; hardware set wins over a same-cycle clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      droop_flag_reg <= 1'b0;
      wdog_flag_reg <= 1'b0;
    end else begin
      droop_flag_reg <= volt_reset || (droop_flag_reg && !I_CLR_DROOP_FLAG);
      wdog_flag_reg <= wdog_reset || (wdog_flag_reg && !I_CLR_WDOG_FLAG);
    end
  end

  // Read data, resonator output, aux port and wake pulse
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rdata_reg <= CKR_READ_IDLE;
      xout_reg <= 1'b0;
      aux_reg <= 1'b0;
      wake_irq_reg <= 1'b0;
      restart_reg <= 1'b0;
    end else begin
      rdata_reg <= cfg_rd ? cfg_reg : CKR_READ_IDLE;
      xout_reg <= cfg_reg[CKR_BIT_CLKOUT_DIS] | I_INT_OSC_CLK;
      aux_reg <= !clk_ext_reg && I_RESONATOR_INPUT_PIN;
      wake_irq_reg <= I_WAKE_TICK && I_WAKE_INT_EN;
      restart_reg <= !run_state && (state_next == CKR_ST_RUN) && !osc_wait;
    end
  end

  // Delay counter for start-up, oscillator start and resume
  ckr_delay_timer #(
    .W(CKR_CNT_W)
  ) u_timer (
    .i_clk(I_CORE_CLK),
    .i_rst_n(I_RST_N),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Bus and flag outputs
  assign O_IO_RDATA = rdata_reg;
  assign O_DROOP_RESET_FLAG = droop_flag_reg;
  assign O_WDOG_RESET_FLAG = wdog_flag_reg;

  // Oscillator and clock gating outputs
  wire logic clocks_off = in_suspend || osc_wait;
  assign O_INT_OSC_EN = !clk_ext_reg && !in_suspend;
  assign O_EXT_OSC_EN = clk_ext_reg && !in_suspend;
  assign O_CLK_SRC_EXT = clk_ext_reg;
  assign O_SYS_CLK_EN = !clocks_off && !(state_reg == CKR_ST_HOLD);
  assign O_CLK_TUNE_EN = !clk_ext_reg && cfg_reg[CKR_BIT_TUNE_EN] && I_USB_TRAFFIC;

  // Resonator pins: driven only in internal mode
  assign O_RESONATOR_IN_PULLDOWN = !clk_ext_reg;
  assign O_RESONATOR_OUTPUT_PIN = xout_reg;
  assign O_RESONATOR_OUTPUT_OE_N = clk_ext_reg;
  assign O_AUX_PORT_BIT_ONE = aux_reg;

  // Wake-up timer controls
  assign O_WAKE_PERIOD = cfg_reg[CKR_WAKE_HI:CKR_WAKE_LO];
  assign O_WAKE_IRQ = wake_irq_reg;

  // Core reset and hold outputs
  assign O_CHIP_RESET = (state_reg == CKR_ST_HOLD) || (state_reg == CKR_ST_STARTUP)
    || (state_reg == CKR_ST_WDOG);
  assign O_PARTIAL_SUSPEND = (state_reg == CKR_ST_STARTUP);
  assign O_CPU_HOLD = !run_state;
  assign O_DROOP_DETECT_EN = droop_armed;
  assign O_CPU_RESTART = restart_reg;
  assign O_RESET_VECTOR = CKR_RESET_VECTOR;
  assign O_STACK_RESET_VALUE = CKR_STACK_RESET;
endmodule : ckr_clock_reset_ctrl

// *** test/ckr_clock_reset_ctrl_properties.sv ***
// Concurrent checks on the ports of the clock source and reset controller.
// Assumes it is bound into ckr_clock_reset_ctrl and sees only its ports.
`timescale 1ns/1ps
module ckr_clock_reset_ctrl_properties
  import ckr_pkg::*;
#(
  parameter int RESUME_LONG_CYC = 40,
  parameter int RESUME_SHORT_CYC = 20
) (
  // Clock, reset and bus
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic [7:0] I_IO_ADDR,
  input wire logic [7:0] I_IO_WDATA,
  input wire logic I_IO_WR,
  input wire logic I_IO_RD,
  input wire logic [7:0] O_IO_RDATA,
  // Reset sources and wake
  input wire logic I_SUPPLY_DROOP,
  input wire logic I_DEEP_UNDERVOLTAGE,
  input wire logic I_WATCHDOG_EXPIRY,
  input wire logic I_WAKE_TICK,
  input wire logic I_WAKE_INT_EN,
  // Watched outputs
  input wire logic O_CLK_SRC_EXT,
  input wire logic O_SYS_CLK_EN,
  input wire logic O_INT_OSC_EN,
  input wire logic O_EXT_OSC_EN,
  input wire logic O_RESONATOR_OUTPUT_OE_N,
  input wire logic [2:0] O_WAKE_PERIOD,
  input wire logic O_WAKE_IRQ,
  input wire logic O_CHIP_RESET,
  input wire logic O_CPU_HOLD,
  input wire logic O_CPU_RESTART,
  input wire logic [15:0] O_RESET_VECTOR,
  input wire logic [7:0] O_STACK_RESET_VALUE,
  input wire logic O_DROOP_RESET_FLAG,
  input wire logic O_WDOG_RESET_FLAG
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  int hold_cnt_reg;
  logic quiet;
  logic cfg_wr;
  // No reset source active, and a configuration write in RUN
  assign quiet = !I_SUPPLY_DROOP && !I_DEEP_UNDERVOLTAGE && !I_WATCHDOG_EXPIRY;
  assign cfg_wr = I_IO_WR && I_IO_ADDR == CKR_CFG_ADDR && !O_CPU_HOLD && quiet;
  // Counts cycles held with clocks running, outside chip reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) hold_cnt_reg <= 0;
    else if (O_CPU_HOLD && O_SYS_CLK_EN && !O_CHIP_RESET) hold_cnt_reg <= hold_cnt_reg + 1;
    else hold_cnt_reg <= 0;
  end
  chk_cfg_write: assert property (cfg_wr |=> O_WAKE_PERIOD == $past(I_IO_WDATA[6:4]))
    else $error("wake period does not follow config write");
  chk_switch_halt: assert property (cfg_wr && I_IO_WDATA[0] && !O_CLK_SRC_EXT
    |=> O_CPU_HOLD && !O_SYS_CLK_EN && O_EXT_OSC_EN && !O_INT_OSC_EN)
    else $error("clock switch did not halt and start resonator");
  chk_resume_time: assert property ($fell(O_CPU_HOLD) && O_CLK_SRC_EXT && !$past(O_CHIP_RESET)
    |-> hold_cnt_reg >= RESUME_SHORT_CYC - 1 && hold_cnt_reg <= RESUME_LONG_CYC + 4)
    else $error("external resume delay out of range");
  chk_ext_pin: assert property (O_CLK_SRC_EXT |-> O_RESONATOR_OUTPUT_OE_N)
    else $error("resonator output driven in external mode");
  chk_volt_reset: assert property (I_DEEP_UNDERVOLTAGE
    |=> O_CHIP_RESET && O_DROOP_RESET_FLAG && !O_CLK_SRC_EXT)
    else $error("undervoltage did not reset into internal mode");
  chk_wdog_reset: assert property (I_WATCHDOG_EXPIRY && !I_SUPPLY_DROOP && !I_DEEP_UNDERVOLTAGE
    && !O_CHIP_RESET |=> O_CHIP_RESET && O_WDOG_RESET_FLAG && $stable(O_CLK_SRC_EXT))
    else $error("watchdog reset wrong");
  chk_restart_pulse: assert property (O_CPU_RESTART |-> !O_CPU_HOLD ##1 !O_CPU_RESTART)
    else $error("restart pulse wrong");
  chk_restart_values: assert property (O_RESET_VECTOR == CKR_RESET_VECTOR
    && O_STACK_RESET_VALUE == CKR_STACK_RESET)
    else $error("restart vector or stack value wrong");
  chk_wake_irq: assert property (I_WAKE_TICK |=> O_WAKE_IRQ == $past(I_WAKE_INT_EN))
    else $error("wake interrupt gating wrong");
  chk_read_idle: assert property (I_IO_RD && I_IO_ADDR != CKR_CFG_ADDR |=> O_IO_RDATA == 8'h00)
    else $error("unmapped read not zero");
endmodule : ckr_clock_reset_ctrl_properties
bind ckr_clock_reset_ctrl ckr_clock_reset_ctrl_properties #(
  .RESUME_LONG_CYC(RESUME_LONG_CYC),
  .RESUME_SHORT_CYC(RESUME_SHORT_CYC)
) i_ckr_clock_reset_ctrl_properties (
  .I_CORE_CLK, .I_RST_N, .I_IO_ADDR, .I_IO_WDATA, .I_IO_WR, .I_IO_RD, .O_IO_RDATA,
  .I_SUPPLY_DROOP, .I_DEEP_UNDERVOLTAGE, .I_WATCHDOG_EXPIRY, .I_WAKE_TICK, .I_WAKE_INT_EN,
  .O_CLK_SRC_EXT, .O_SYS_CLK_EN, .O_INT_OSC_EN, .O_EXT_OSC_EN, .O_RESONATOR_OUTPUT_OE_N,
  .O_WAKE_PERIOD, .O_WAKE_IRQ, .O_CHIP_RESET, .O_CPU_HOLD, .O_CPU_RESTART, .O_RESET_VECTOR,
  .O_STACK_RESET_VALUE, .O_DROOP_RESET_FLAG, .O_WDOG_RESET_FLAG
);

// *** test/ckr_osc_model.sv ***
// Behavioural resonator and internal oscillator seen by the controller.
// Assumes the enables come straight from the controller.
`timescale 1ns/1ps
module ckr_osc_model #(
  parameter int DLY = 10
) (
  // Clock and enables
  input wire logic i_clk,
  input wire logic i_ext_en,
  input wire logic i_int_en,
  // Oscillator status
  output logic o_stable,
  output logic o_int_clk
);
  int cnt = 0;
  // Resonator settles DLY cycles after enable, drops at once when disabled
  always @(posedge i_clk) begin
    if (!i_ext_en) cnt <= 0;
    else if (cnt < DLY) cnt <= cnt + 1;
  end
  assign o_stable = i_ext_en && cnt >= DLY;
  // Internal oscillator near 6 MHz, stopped low when disabled
  initial o_int_clk = 1'b0;
  always #83 o_int_clk = i_int_en ? ~o_int_clk : 1'b0;
endmodule : ckr_osc_model

// *** test/ckr_clock_reset_ctrl_tb.sv ***
// Self-checking bench for the clock source and reset controller.
// Assumes short delay parameters and the oscillator model on the far side.
`timescale 1ns/1ps
module ckr_clock_reset_ctrl_tb;
  import ckr_pkg::*;
  localparam int LONG = 40;
  localparam int SHORT = 20;
  localparam int START = 30;
  localparam int DLY = 10;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, droop = 0, deep = 0, wdog = 0, susp = 0;
  logic wake = 0, tick = 0, tick_en = 0, usb = 0, xin = 0, clr_d = 0, clr_w = 0, look = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
  logic int_en, ext_en, int_clk, stable, src_ext, hold, oe_n, aux, fl_d, fl_w;
  logic [2:0] period;
  logic [16:0] st;
  logic [33:0] e;
  logic [33:0] exq[$];
  int err_count = 0, samples_checked = 0, n;
  // Clock and status word
  always #4 clk = ~clk;
  assign st = {rdata, fl_d, fl_w, hold, src_ext, oe_n, aux, period};
  ckr_clock_reset_ctrl #(.RESUME_LONG_CYC(LONG), .RESUME_SHORT_CYC(SHORT), .STARTUP_CYC(START))
  i_ckr_clock_reset_ctrl (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_IO_ADDR(addr), .I_IO_WDATA(wdata), .I_IO_WR(wr),
    .I_IO_RD(rd), .O_IO_RDATA(rdata), .I_SUPPLY_DROOP(droop), .I_DEEP_UNDERVOLTAGE(deep),
    .I_WATCHDOG_EXPIRY(wdog), .I_SUSPEND_REQ(susp), .I_WAKE_EVENT(wake), .I_WAKE_TICK(tick),
    .I_WAKE_INT_EN(tick_en), .I_USB_TRAFFIC(usb), .I_INT_OSC_CLK(int_clk),
    .I_EXT_OSC_STABLE(stable), .O_INT_OSC_EN(int_en), .O_EXT_OSC_EN(ext_en),
    .O_CLK_SRC_EXT(src_ext), .O_SYS_CLK_EN(), .O_CLK_TUNE_EN(), .I_RESONATOR_INPUT_PIN(xin),
    .O_RESONATOR_IN_PULLDOWN(), .O_RESONATOR_OUTPUT_PIN(), .O_RESONATOR_OUTPUT_OE_N(oe_n),
    .O_AUX_PORT_BIT_ONE(aux), .O_WAKE_PERIOD(period), .O_WAKE_IRQ(), .O_CHIP_RESET(),
    .O_CPU_HOLD(hold), .O_PARTIAL_SUSPEND(), .O_DROOP_DETECT_EN(), .O_CPU_RESTART(),
    .O_RESET_VECTOR(), .O_STACK_RESET_VALUE(), .I_CLR_DROOP_FLAG(clr_d),
    .I_CLR_WDOG_FLAG(clr_w), .O_DROOP_RESET_FLAG(fl_d), .O_WDOG_RESET_FLAG(fl_w)
  );
  ckr_osc_model #(.DLY(DLY)) i_ckr_osc_model (
    .i_clk(clk), .i_ext_en(ext_en), .i_int_en(int_en), .o_stable(stable), .o_int_clk(int_clk)
  );
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task conclude;
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // Read cycle; the expected status word is queued for the monitor
  task rdx(input logic [7:0] a, input logic [16:0] m, input logic [16:0] v);
    @(negedge clk);
    addr = a;
    rd = 1;
    exq.push_back({m, v & m});
    @(negedge clk);
    rd = 0;
  endtask : rdx
  task wrx(input logic [7:0] a, input logic [7:0] dv);
    @(negedge clk);
    addr = a;
    wdata = dv;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask : wrx
  task look_cfg(input logic [7:0] c, input logic fd, fw, h, x, oe);
    rdx(8'hF8, 17'h1_FFFF, {c, fd, fw, h, x, oe, x ? 1'b0 : xin, c[6:4]});
  endtask : look_cfg
  // Counts cycles until the processor runs, bounded
  task run_wait(input int lim);
    n = 0;
    while (hold === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (hold !== 1'b0) check(hold, 0);
  endtask : run_wait
  // Result monitor: compares the oldest note one cycle after each read
  always @(posedge clk) look <= rd;
  always @(negedge clk) begin
    if (look) begin
      e = exq.pop_front();
      check(st & e[33:17], e[16:0]);
    end
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    n = $urandom(78020);
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    run_wait(200);
    check(n >= START, 1);
    look_cfg(8'h00, 0, 0, 0, 0, 0);
    for (int i = 0; i < 4; i++) begin
      xin = 1'($urandom);
      tick_en = 1'($urandom);
      usb = 1'($urandom);
      d = 8'($urandom) & 8'hFE;
      wrx(8'hF8, d);
      tick = 1;
      wrx(8'h26, ~d);
      tick = 0;
      look_cfg(d, 0, 0, 0, 0, 0);
    end
    rdx(8'h26, 17'h1_FE00, 17'h0_0000);
    wrx(8'hF8, 8'h81);
    look_cfg(8'h81, 0, 0, 1, 1, 1);
    run_wait(300);
    check(n >= LONG && n <= LONG + DLY + 8, 1);
    wrx(8'hF8, 8'h00);
    look_cfg(8'h00, 0, 0, 0, 1, 1);
    susp = 1;
    @(negedge clk);
    susp = 0;
    repeat (3) @(negedge clk);
    wake = 1;
    @(negedge clk);
    wake = 0;
    run_wait(3000);
    check(n >= 1125 && n <= 1160, 1);
    look_cfg(8'h00, 0, 0, 0, 0, 0);
    wrx(8'hF8, 8'h01);
    run_wait(300);
    check(n >= SHORT && n <= SHORT + DLY + 8, 1);
    wdog = 1;
    repeat (3) @(negedge clk);
    wdog = 0;
    run_wait(50);
    check(n <= 8, 1);
    look_cfg(8'h00, 0, 1, 0, 1, 1);
    clr_w = 1;
    wrx(8'hF8, 8'h08);
    clr_w = 0;
    droop = 1;
    look_cfg(8'h08, 0, 0, 0, 1, 1);
    wrx(8'hF8, 8'h00);
    look_cfg(8'h00, 1, 0, 1, 0, 0);
    droop = 0;
    run_wait(200);
    check(n >= START, 1);
    clr_d = 1;
    wrx(8'hF8, 8'h08);
    clr_d = 0;
    deep = 1;
    repeat (2) @(negedge clk);
    deep = 0;
    run_wait(200);
    look_cfg(8'h00, 1, 0, 0, 0, 0);
    @(negedge clk);
    conclude();
  end
endmodule : ckr_clock_reset_ctrl_tb
